// *** ualbp_baud.sv ***
// Purpose: Divisor counter producing the sixteen-per-bit oversampling tick
// Assumes: clk is the instruction clock
// Notes:   Counter freezes while the port clock is stopped
`timescale 1ns/1ps
`include "ualbp_params.svh"
module ualbp_baud
(
  input  wire logic   clk,    // Instruction clock
  input  wire logic   rst,    // Async reset, active high
  ualbp_baud_if.gen   bif     // Divisor, run and tick
);
  import ualbp_pkg::*;

  ualbp_div_t cnt_ff;
  ualbp_div_t nxt_cnt;
  logic       tick_ff;
  wire        expire = (cnt_ff == 16'h0000);

  // ----------------------------------------
  // Reload on expiry
  // ----------------------------------------
  // Period is divisor plus one cycles
  assign nxt_cnt  = expire ? bif.divisor : cnt_ff - 16'h0001;
  assign bif.tick = tick_ff;

  // Held still in sleep so no tick leaks out
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff  <= `UALBP_BRG_RST;
      tick_ff <= 1'b0;
    end
    else if (bif.run)
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= expire;
    end
    else
      tick_ff <= 1'b0;
  end
endmodule

// *** ualbp_baud_if.sv ***
// Purpose: Carrier between the port logic and its baud divider
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle enable pulse
`timescale 1ns/1ps
interface ualbp_baud_if;
  import ualbp_pkg::*;
  ualbp_div_t divisor;  // Reload value
  logic       run;      // Port clock running
  logic       tick;     // Oversampling enable

  modport gen  (input divisor, input run, output tick);
  modport user (output divisor, output run, input tick);
endinterface

// *** ualbp_bench.sv ***
// Purpose: Self-checking run of the port features
// Assumes: Divisor 0 or 1 keeps frames short
// Notes:   One task per scenario
`timescale 1ns/1ps
`include "ualbp_params.svh"
module ualbp_bench;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [4:0]  paddr     = 5'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic        sleep_req = 1'b0;
  logic        idle_req  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        tx_pin;
  logic        rx_irq;
  logic        cap_one;
  logic        cap_two;
  int          n_fail    = 0;
  int          n_checks  = 0;
  int          irq_n     = 0;
  localparam logic [31:0] M_EN = 32'h1 << `UALBP_MODE_EN, M_SIDL = 32'h1 << `UALBP_MODE_SIDL,
    M_WAKE = 32'h1 << `UALBP_MODE_WAKE, M_LPBK = 32'h1 << `UALBP_MODE_LPBK,
    M_ABD = 32'h1 << `UALBP_MODE_ABAUD, M_NINE = 32'h1 << `UALBP_MODE_NINE,
    S_TXEN = 32'h1 << `UALBP_STAT_TXEN, S_ADDR = 32'h1 << `UALBP_STAT_ADDRESS_MATCH_ENABLE,
    S_SEL = {30'h0, `UALBP_SEL_FULL} << `UALBP_STAT_SEL_LO;

  always #50 clk = ~clk;

  ualbp_top #(.RX_DEPTH(4), .PORT_NUM(1)) DUT
  (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .idle_req(idle_req),
    .serial_in_pin(rx_pin), .serial_out_pin(tx_pin), .rx_irq(rx_irq),
    .capture_input_one(cap_one), .capture_input_two(cap_two)
  );

  ualbp_line_model lm (.clk(clk), .line_tx(rx_pin), .line_rx(tx_pin));

  // Count pulses so none is missed
  always @(posedge clk)
    if (rx_irq === 1'b1)
      irq_n++;

  // ------------------------
  // Bus, compare and closing tasks
  // ------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------
  // Scenarios
  // ------------------------
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rdc(`UALBP_OFF_BRG, 32'h0000_0000);
    wr(`UALBP_OFF_BRG, 32'hABCD_FFFF);
    rdc(`UALBP_OFF_BRG, 32'h0000_FFFF);
    apb(1'b0, 5'h14, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    wr(`UALBP_OFF_BRG, 32'h0000_0000);
  endtask

  // Held-low external pin must not disturb the looped frame
  task automatic t_loop;
    int n0;
    n0 = irq_n;
    wr(`UALBP_OFF_MODE, M_EN);
    wr(`UALBP_OFF_MODE, M_EN | M_LPBK);
    wr(`UALBP_OFF_STAT, S_TXEN);
    lm.line_tx <= 1'b0;
    wr(`UALBP_OFF_TXD, 32'h0000_00A5);
    cyc(200);
    lm.line_tx <= 1'b1;
    chk(irq_n - n0, 1);
    chk(lm.last_rx, 32'h0000_00A5);
    rdc(`UALBP_OFF_RXD, 32'h0000_00A5);
  endtask

  task automatic t_addr;
    int n0;
    wr(`UALBP_OFF_BRG, 32'h0000_0001);
    lm.bl = 32;
    lm.nb = 9;
    wr(`UALBP_OFF_MODE, M_EN | M_NINE);
    wr(`UALBP_OFF_STAT, S_ADDR | S_SEL);
    n0 = irq_n;
    lm.send(9'h1A5);
    chk(irq_n - n0, 1);
    lm.send(9'h0A5);
    chk(irq_n - n0, 1);
    rdc(`UALBP_OFF_RXD, 32'h0000_01A5);
    rdc(`UALBP_OFF_RXD, 32'h0000_00A5);
    lm.nb = 8;
    wr(`UALBP_OFF_MODE, M_EN);
    for (int i = 0; i < 4; i++)
    begin
      lm.send(9'(9'h180 + i));
      chk(irq_n - n0, (i == 3) ? 2 : 1);
    end
    for (int i = 0; i < 4; i++)
      rdc(`UALBP_OFF_RXD, 32'h0000_0080 + i);
    wr(`UALBP_OFF_BRG, 32'h0000_0000);
    lm.bl = 16;
  endtask

  task automatic t_idle;
    int n0;
    wr(`UALBP_OFF_MODE, M_EN | M_LPBK);
    wr(`UALBP_OFF_STAT, S_TXEN);
    idle_req <= 1'b1;
    n0 = irq_n;
    wr(`UALBP_OFF_TXD, 32'h0000_003C);
    cyc(200);
    chk(irq_n - n0, 1);
    wr(`UALBP_OFF_MODE, M_EN | M_LPBK | M_SIDL);
    wr(`UALBP_OFF_TXD, 32'h0000_0066);
    cyc(200);
    chk(irq_n - n0, 1);
    idle_req <= 1'b0;
    cyc(200);
    chk(irq_n - n0, 2);
    rdc(`UALBP_OFF_RXD, 32'h0000_003C);
    rdc(`UALBP_OFF_RXD, 32'h0000_0066);
  endtask

  task automatic t_cap;
    wr(`UALBP_OFF_MODE, M_EN | M_ABD);
    lm.line_tx <= 1'b0;
    cyc(4);
    chk(cap_one, 32'h0000_0000);
    lm.line_tx <= 1'b1;
    cyc(4);
    chk(cap_one, 32'h0000_0001);
    chk(cap_two, 32'h0000_0000);
    wr(`UALBP_OFF_MODE, M_EN);
    chk(cap_one, 32'h0000_0000);
  endtask

  // Sleep lands mid-frame in both directions at once
  task automatic t_sleep;
    int          n0;
    logic [31:0] r;
    logic        e;
    wr(`UALBP_OFF_MODE, M_EN | M_WAKE);
    wr(`UALBP_OFF_STAT, S_TXEN);
    fork
      lm.send(9'h00F);
    join_none
    wr(`UALBP_OFF_TXD, 32'h0000_0000);
    cyc(60);
    sleep_req <= 1'b1;
    cyc(4);
    chk(tx_pin, 32'h0000_0001);
    cyc(250);
    n0 = irq_n;
    lm.line_tx <= 1'b0;
    cyc(10);
    chk(irq_n - n0, 1);
    lm.line_tx <= 1'b1;
    wr(`UALBP_OFF_MODE, M_WAKE);
    lm.line_tx <= 1'b0;
    cyc(10);
    chk(irq_n - n0, 1);
    lm.line_tx <= 1'b1;
    sleep_req <= 1'b0;
    cyc(4);
    apb(1'b0, `UALBP_OFF_STAT, 32'h0000_0000, r, e);
    chk(r & 32'h0000_0001, 32'h0000_0000);
    rdc(`UALBP_OFF_MODE, M_WAKE);
    rdc(`UALBP_OFF_BRG, 32'h0000_0000);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_loop;
    t_addr;
    t_idle;
    t_cap;
    t_sleep;
    summarize;
  end

  // Watchdog, about five and a half times the run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end
endmodule

// *** ualbp_chk.sv ***
// Purpose: Port-level assertions for the serial port auxiliary block
// Assumes: One clock domain, zero-wait APB
// Notes:   Divisor shadow is rebuilt from bus writes
`timescale 1ns/1ps
`include "ualbp_params.svh"
module ualbp_chk
#(
  parameter int RX_DEPTH = 4, // Receive buffer words
  parameter int PORT_NUM = 1  // Capture input in use
)
(
  input wire logic        clk, // Clock
  input wire logic        rst, // Reset
  input wire logic        psel, // APB select
  input wire logic        penable, // APB access
  input wire logic        pwrite, // APB direction
  input wire logic [4:0]  paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic        pready, // APB ready
  input wire logic        pslverr, // APB error
  input wire logic        sleep_req, // Sleep
  input wire logic        idle_req, // Idle
  input wire logic        serial_in_pin, // Receive pin
  input wire logic        serial_out_pin, // Transmit pin
  input wire logic        rx_irq, // Receive event
  input wire logic        capture_input_one, // Capture one
  input wire logic        capture_input_two  // Capture two
);
  // ------------------------
  // Helper state
  // ------------------------
  logic [15:0]      div_ff;  // Divisor as last written
  logic             last_ff; // Transmit pin one cycle back
  int               age_ff;  // Samples the old pin level lasted
  logic [3:0]       slp_ff;  // Sleep cycles, saturating at 8
  logic [3:0]       low_ff;  // Cycles since receive pin was high
  int               nxt_age;
  int               bit_len;
  wire logic        acc     = psel && penable && pready;
  wire logic        moved   = serial_out_pin != last_ff;
  wire logic        div_wr  = acc && pwrite && paddr == `UALBP_OFF_BRG;
  wire logic [15:0] nxt_div = div_wr ? pwdata[15:0] : div_ff;
  wire logic [3:0]  nxt_slp = !sleep_req ? 4'h0 : (slp_ff == 4'h8 ? slp_ff : slp_ff + 4'h1);
  wire logic [3:0]  nxt_low = serial_in_pin ? 4'h0 : (low_ff == 4'hF ? low_ff : low_ff + 4'h1);
  assign nxt_age = moved ? 1 : age_ff + 1;
  assign bit_len = 16 * (int'(div_ff) + 1);

  // Reset clears stale run lengths
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_ff  <= `UALBP_BRG_RST;
      last_ff <= 1'b1;
      age_ff  <= 0;
      slp_ff  <= 4'h0;
      low_ff  <= 4'h0;
    end
    else
    begin
      div_ff  <= nxt_div;
      last_ff <= serial_out_pin;
      age_ff  <= nxt_age;
      slp_ff  <= nxt_slp;
      low_ff  <= nxt_low;
    end
  end

  // ------------------------
  // Assertions
  // ------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_asleep;
    sleep_req ##1 sleep_req;
  endsequence

  // A rise ends whole bits; sleep and idle aborts excluded
  sequence s_bit_end;
    serial_out_pin && !last_ff && !sleep_req && !idle_req ##0 !$past(sleep_req) && !$past(idle_req);
  endsequence

  a_err_access:
    assert property (pslverr |-> psel && penable) else $error("error flag outside access");
  a_unmapped_err:
    assert property (psel && penable && paddr > `UALBP_OFF_BRG |-> pslverr)
      else $error("unmapped access not refused");
  a_div_readback:
    assert property (acc && !pwrite && paddr == `UALBP_OFF_BRG |-> prdata == {16'h0000, div_ff})
      else $error("divisor readback wrong");
  a_bit_timing:
    assert property (s_bit_end |-> age_ff % bit_len == 0) else $error("bit length wrong");
  a_sleep_line_high:
    assert property (s_asleep |-> serial_out_pin) else $error("transmit pin low in sleep");
  a_wake_cause:
    assert property (slp_ff == 4'h8 && rx_irq |-> low_ff != 4'h0 && low_ff <= 4'h6)
      else $error("sleep irq without falling edge");
  a_capture_follow:
    assert property (capture_input_one |-> $past(serial_in_pin, 2))
      else $error("capture one not following pin");
  a_capture_two_off:
    assert property (PORT_NUM == 1 |-> !capture_input_two) else $error("wrong capture input");
  a_irq_pulse:
    assert property (rx_irq |=> !rx_irq) else $error("irq longer than one cycle");
endmodule

bind ualbp_top ualbp_chk #(.RX_DEPTH(RX_DEPTH), .PORT_NUM(PORT_NUM)) u_chk
(
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_req(sleep_req), .idle_req(idle_req),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .rx_irq(rx_irq),
  .capture_input_one(capture_input_one), .capture_input_two(capture_input_two)
);

// *** ualbp_line_model.sv ***
// Purpose: Remote serial transceiver standing on the line pins
// Assumes: Idle line high, one stop bit, data LSB first
// Notes:   Bench sets bit length and word size
`timescale 1ns/1ps
module ualbp_line_model
(
  input  wire logic clk,     // Instruction clock
  output logic      line_tx, // Drives the port receive pin
  input  wire logic line_rx  // Watches the port transmit pin
);
  int         bl = 16;  // Clocks per bit
  int         nb = 8;   // Data bits per word
  int         n_rx = 0; // Words heard
  logic [8:0] last_rx;  // Last word heard

  initial line_tx = 1'b1;

  // ------------------------
  // Sender: start, data, then three bits high for stop and idle
  // ------------------------
  task automatic send(input logic [8:0] w);
    line_tx <= 1'b0;
    repeat (bl) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      line_tx <= w[i];
      repeat (bl) @(posedge clk);
    end
    line_tx <= 1'b1;
    repeat (3 * bl) @(posedge clk);
  endtask

  // Listener samples mid-bit; aborted frames count too
  initial
  begin
    forever
    begin
      @(negedge line_rx);
      last_rx = 9'h000;
      repeat (bl / 2) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
        repeat (bl) @(posedge clk);
        last_rx[i] = line_rx;
      end
      repeat (bl) @(posedge clk);
      n_rx++;
    end
  end
endmodule

// *** ualbp_params.svh ***
// Purpose: Register map, field positions and timing counts of the serial port
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef UALBP_PARAMS_SVH
`define UALBP_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UALBP_OFF_MODE      5'h00
`define UALBP_OFF_STAT      5'h04
`define UALBP_OFF_TXD       5'h08
`define UALBP_OFF_RXD       5'h0C
`define UALBP_OFF_BRG       5'h10

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define UALBP_MODE_EN       15
`define UALBP_MODE_SIDL     13
`define UALBP_MODE_WAKE     7
`define UALBP_MODE_LPBK     6
`define UALBP_MODE_ABAUD    5
`define UALBP_MODE_NINE     0

// ----------------------------------------
// Status and control register fields
// ----------------------------------------
`define UALBP_STAT_TXEN     10
`define UALBP_STAT_TXFULL   9
`define UALBP_STAT_SEL_HI   7
`define UALBP_STAT_SEL_LO   6
`define UALBP_STAT_ADDRESS_MATCH_ENABLE    5
`define UALBP_STAT_RIDLE    4
`define UALBP_STAT_OERR     1
`define UALBP_STAT_RXDA     0

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define UALBP_BRG_RST       16'h0000
`define UALBP_REG_RST       16'h0000
`define UALBP_TICK_LAST     4'hF
`define UALBP_TICK_MID      4'h7
`define UALBP_BITS8         4'h8
`define UALBP_BITS9         4'h9
`define UALBP_SEL_THREE     2'b10
`define UALBP_SEL_FULL      2'b11
`define UALBP_LVL_THREE     3
`define UALBP_LVL_FULL      4

`endif

// *** ualbp_pkg.sv ***
// Purpose: Shared types of the serial port auxiliary block
// Assumes: Constants live in ualbp_params.svh
// Notes:   Types only
package ualbp_pkg;

  // ----------------------------------------
  // Receiver and transmitter states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ualbp_rx_st_t;

  typedef enum logic [0:0]
  {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } ualbp_tx_st_t;

  typedef logic [15:0] ualbp_div_t;

endpackage

// *** ualbp_top.sv ***
// Purpose: Serial port with address detect, loopback, baud divisor, sleep and idle
// Assumes: APB slave, zero wait states; sleep and idle requests on clk
// Notes:   Receive FIFO holds RX_DEPTH words beside the shift register
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "ualbp_params.svh"

module ualbp_top
#(
  parameter int RX_DEPTH = 4,   // Receive buffer words
  parameter int PORT_NUM = 1    // Selects capture input one or two
)
(
  input  wire logic        clk,                // Instruction clock
  input  wire logic        rst,                // Async reset, active high
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB access phase
  input  wire logic        pwrite,             // APB direction
  input  wire logic [4:0]  paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error on unmapped
  input  wire logic        sleep_req,          // Device in sleep
  input  wire logic        idle_req,           // Device in idle
  input  wire logic        serial_in_pin,      // Line receive pin
  output logic             serial_out_pin,     // Line transmit pin
  output logic             rx_irq,             // Receive interrupt event pulse
  output logic             capture_input_one,  // Receive to capture one
  output logic             capture_input_two   // Receive to capture two
);
  import ualbp_pkg::*;

  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CW = $clog2(RX_DEPTH + 1);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if ((RX_DEPTH < 4) || ((RX_DEPTH & (RX_DEPTH - 1)) != 0))
    $error("RX_DEPTH must be a power of two, at least four");
  if ((PORT_NUM != 1) && (PORT_NUM != 2))
    $error("PORT_NUM must be one or two");

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0]  mode_reg_ff;
  logic [15:0]  ctl_ff;
  ualbp_div_t   baud_divisor_ff;
  logic         oerr_ff;
  logic [8:0]   txh_ff;
  logic         txh_full_ff;
  logic [31:0]  prdata_ff;
  logic         rx_irq_ff;
  logic         out_ff;
  logic         in_s1_ff;
  logic         in_s2_ff;
  logic         in_s3_ff;
  ualbp_rx_st_t rx_st_ff;
  ualbp_tx_st_t tx_st_ff;
  logic [3:0]   rx_tick_ff;
  logic [3:0]   rx_bit_ff;
  logic [8:0]   rx_sh_ff;
  logic [3:0]   tx_tick_ff;
  logic [3:0]   tx_bit_ff;
  logic [10:0]  tx_sh_ff;
  logic [8:0]   mem_ff [RX_DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;

  ualbp_baud_if bif ();

  ualbp_baud u_baud
  (
    .clk (clk),
    .rst (rst),
    .bif (bif)
  );

  // ----------------------------------------
  // Power state and control decode
  // ----------------------------------------
  wire mod_en  = mode_reg_ff[`UALBP_MODE_EN];
  wire sidl    = mode_reg_ff[`UALBP_MODE_SIDL];
  wire wake_en = mode_reg_ff[`UALBP_MODE_WAKE];
  wire lpbk    = mode_reg_ff[`UALBP_MODE_LPBK];
  wire abaud   = mode_reg_ff[`UALBP_MODE_ABAUD];
  wire nine    = mode_reg_ff[`UALBP_MODE_NINE];
  wire txen    = ctl_ff[`UALBP_STAT_TXEN];
  wire addr_md = ctl_ff[`UALBP_STAT_ADDRESS_MATCH_ENABLE] & nine;
  wire [1:0] rx_sel = ctl_ff[`UALBP_STAT_SEL_HI:`UALBP_STAT_SEL_LO];
  // Idle halts only when stop-in-idle is set
  wire run     = mod_en & ~sleep_req & ~(idle_req & sidl);
  wire tick    = bif.tick;
  wire [3:0] nbits = nine ? `UALBP_BITS9 : `UALBP_BITS8;

  assign bif.divisor = baud_divisor_ff;
  assign bif.run     = run;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire hit_mod = (paddr == `UALBP_OFF_MODE);
  wire hit_sta = (paddr == `UALBP_OFF_STAT);
  wire hit_txd = (paddr == `UALBP_OFF_TXD);
  wire hit_rxd = (paddr == `UALBP_OFF_RXD);
  wire hit_brg = (paddr == `UALBP_OFF_BRG);
  wire mapped  = hit_mod | hit_sta | hit_txd | hit_rxd | hit_brg;
  wire wr      = access & pwrite & mapped;
  wire rd_pop  = access & ~pwrite & hit_rxd & (cnt_ff != '0);
  wire wr_tx   = wr & hit_txd & ~txh_full_ff;   // Full holding ignores the write

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_ff;

  // Status view built from live state
  wire [15:0] stat_view = {ctl_ff[15:10], txh_full_ff, 1'b0, rx_sel,
                           ctl_ff[`UALBP_STAT_ADDRESS_MATCH_ENABLE], (rx_st_ff == RX_IDLE),
                           2'b00, oerr_ff, (cnt_ff != '0)};
  wire [31:0] rd_mux  = hit_mod ? {16'h0000, mode_reg_ff} :
                        hit_sta ? {16'h0000, stat_view} :
                        hit_rxd ? {23'h00_0000, mem_ff[rp_ff]} :
                        hit_brg ? {16'h0000, baud_divisor_ff} :
                        32'h0000_0000;

  // Read data latched in setup so it comes from a flop in access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_ff <= 32'h0000_0000;
    else if (setup)
      prdata_ff <= rd_mux;
  end

  // ----------------------------------------
  // Software registers; sleep never touches them
  // ----------------------------------------
  // Overrun: set by the receiver wins over a software clear
  wire ovr_set = (rx_st_ff == RX_STOP) & tick & (rx_tick_ff == `UALBP_TICK_LAST)
                 & (cnt_ff == CW'(RX_DEPTH));
  wire nxt_oerr = ovr_set | (oerr_ff & ~(wr & hit_sta & ~pwdata[`UALBP_STAT_OERR]));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_reg_ff     <= `UALBP_REG_RST;
      ctl_ff          <= `UALBP_REG_RST;
      baud_divisor_ff <= `UALBP_BRG_RST;
      oerr_ff         <= 1'b0;
    end
    else
    begin
      if (wr & hit_mod)
        mode_reg_ff <= pwdata[15:0];
      if (wr & hit_sta)
        ctl_ff <= pwdata[15:0];
      if (wr & hit_brg)
        baud_divisor_ff <= pwdata[15:0];
      oerr_ff <= nxt_oerr;
    end
  end

  // ----------------------------------------
  // Pin synchroniser and receive source
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_s1_ff <= 1'b1;
      in_s2_ff <= 1'b1;
      in_s3_ff <= 1'b1;
    end
    else
    begin
      in_s1_ff <= serial_in_pin;
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
    end
  end

  // Loopback takes our own line and drops the pin
  wire rx_line = lpbk ? out_ff : in_s2_ff;
  wire pin_fall = in_s3_ff & ~in_s2_ff;

  // Capture routing follows the pin, not the loopback path
  assign capture_input_one = abaud & (PORT_NUM == 1) & in_s2_ff;
  assign capture_input_two = abaud & (PORT_NUM == 2) & in_s2_ff;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  wire rx_last = tick & (rx_tick_ff == `UALBP_TICK_LAST);
  wire rx_done = (rx_st_ff == RX_STOP) & rx_last;
  wire push    = rx_done & (cnt_ff != CW'(RX_DEPTH));
  // Word in the shift register, right aligned for eight-bit frames
  wire [8:0] rx_word = nine ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
  wire rx_ninth_bit = rx_word[8];
  wire is_addr = addr_md & rx_ninth_bit;

  // Sleep or disable returns the receiver to idle mid-frame
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_ff   <= RX_IDLE;
      rx_tick_ff <= 4'h0;
      rx_bit_ff  <= 4'h0;
      rx_sh_ff   <= 9'h000;
    end
    else if (!run)
      rx_st_ff <= RX_IDLE;
    else if (tick)
    begin
      rx_tick_ff <= rx_tick_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE:
        begin
          rx_tick_ff <= 4'h0;
          if (!rx_line && !oerr_ff)
            rx_st_ff <= RX_START;
        end
        RX_START:
          if (rx_tick_ff == `UALBP_TICK_MID)
          begin
            rx_tick_ff <= 4'h0;
            rx_bit_ff  <= 4'h0;
            rx_st_ff   <= rx_line ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_tick_ff == `UALBP_TICK_LAST)
          begin
            rx_sh_ff  <= {rx_line, rx_sh_ff[8:1]};
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == nbits - 4'h1)
              rx_st_ff <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick_ff == `UALBP_TICK_LAST)
            rx_st_ff <= RX_IDLE;
        default:
          rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  // Reading an empty buffer shows the old word and does not shift
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + PW'(1);
      if (rd_pop)
        rp_ff <= rp_ff + PW'(1);
      cnt_ff <= cnt_ff + CW'(push) - CW'(rd_pop);
    end
  end

  // One storage entry per word, written only by a push
  for (genvar i = 0; i < RX_DEPTH; i++)
  begin : g_mem
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        mem_ff[i] <= 9'h000;
      else if (push && (wp_ff == PW'(i)))
        mem_ff[i] <= rx_word;
    end
  end

  // ----------------------------------------
  // Receive interrupt event
  // ----------------------------------------
  wire [CW-1:0] cnt_after = cnt_ff + CW'(1) - CW'(rd_pop);
  wire sel_hit = (rx_sel == `UALBP_SEL_THREE) ? (cnt_after == CW'(`UALBP_LVL_THREE)) :
                 (rx_sel == `UALBP_SEL_FULL)  ? (cnt_after == CW'(`UALBP_LVL_FULL)) :
                 1'b1;
  // Address mode bypasses the select setting entirely
  wire rx_evt  = push & (addr_md ? is_addr : sel_hit);
  // Wake: pin edge while asleep, enable required, select ignored
  wire wake_evt = sleep_req & wake_en & mod_en & pin_fall;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_irq_ff <= 1'b0;
    else
      rx_irq_ff <= rx_evt | wake_evt;
  end

  assign rx_irq = rx_irq_ff;

  // ----------------------------------------
  // Transmit holding word
  // ----------------------------------------
  wire tx_load = run & txen & txh_full_ff & (tx_st_ff == TX_IDLE);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txh_ff      <= 9'h000;
      txh_full_ff <= 1'b0;
    end
    else
    begin
      if (wr_tx)
        txh_ff <= pwdata[8:0];
      txh_full_ff <= wr_tx | (txh_full_ff & ~tx_load);
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // Frame is start, data LSB first, stop; shifted out every sixteen ticks
  wire [10:0] tx_frame = nine ? {1'b1, txh_ff, 1'b0} : {2'b11, txh_ff[7:0], 1'b0};
  wire tx_bitend = tick & (tx_tick_ff == `UALBP_TICK_LAST);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_st_ff   <= TX_IDLE;
      tx_sh_ff   <= 11'h7FF;
      tx_tick_ff <= 4'h0;
      tx_bit_ff  <= 4'h0;
    end
    else if (!run)
      tx_st_ff <= TX_IDLE;
    else
      case (tx_st_ff)
        TX_IDLE:
          if (tx_load)
          begin
            tx_sh_ff   <= tx_frame;
            tx_tick_ff <= 4'h0;
            tx_bit_ff  <= 4'h0;
            tx_st_ff   <= TX_SHIFT;
          end
        TX_SHIFT:
          if (tick)
          begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_bitend)
            begin
              tx_sh_ff  <= {1'b1, tx_sh_ff[10:1]};
              tx_bit_ff <= tx_bit_ff + 4'h1;
              if (tx_bit_ff == nbits + 4'h1)
                tx_st_ff <= TX_IDLE;
            end
          end
        default:
          tx_st_ff <= TX_IDLE;
      endcase
  end

  // Pin always driven; high when idle, asleep or disabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      out_ff <= 1'b1;
    else
      out_ff <= (run && tx_st_ff == TX_SHIFT) ? tx_sh_ff[0] : 1'b1;
  end

  assign serial_out_pin = out_ff;
endmodule
